// >>> rtl/cfr_defs.vh
`ifndef CFR_DEFS_VH
`define CFR_DEFS_VH
// byte addresses of the register bank
`define CFR_ADDR_RANGE_LO 8'h32
`define CFR_ADDR_RANGE_HI 8'h33
`define CFR_ADDR_REF_BYP 8'h38
`define CFR_ADDR_MARKER 8'h3b
`define CFR_ADDR_SWING 8'h48
`define CFR_ADDR_ROUTING 8'h60
// reset values
`define CFR_RST_RANGE 16'ha000
`define CFR_RST_REF_BYP 8'h00
`define CFR_RST_MARKER 8'h00
`define CFR_RST_SWING 8'h00
`define CFR_RST_ROUTING 8'h01
// range code landmarks
`define CFR_RANGE_MIN_REC 16'h2000
// field positions
`define CFR_BIT_REF_BYP 0
`define CFR_BIT_RECV_EN 0
`define CFR_BIT_DC_MODE 1
`define CFR_SWING_HI 1
`define CFR_SWING_LO 0
`define CFR_BIT_SWAP 4
`define CFR_SINGLE_HI 1
`define CFR_SINGLE_LO 0
// field encodings
`define CFR_SWING_HIGH 2'h0
`define CFR_SWING_LOW 2'h1
`define CFR_SWING_RSVD 2'h2
`define CFR_SWING_HIZ 2'h3
`define CFR_SINGLE_A 2'h1
`define CFR_SINGLE_B 2'h2
`endif

// >>> rtl/cfr_byte_reg.v
`include "cfr_defs.vh"
// one byte-wide read/write register with a synchronous reset value
module cfr_byte_reg #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire writeEn,
  input wire [7:0] writeData,
  output reg [7:0] value_q
);
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      value_q <= RESET_VALUE;
    end else if (writeEn) begin
      value_q <= writeData;
    end
  end
endmodule // cfr_byte_reg

// >>> rtl/cfr_read_mux.v
`include "cfr_defs.vh"
// registered read-data selection; unmapped bytes answer zero
module cfr_read_mux (
  input wire sys_clk,
  input wire sys_rst,
  input wire load,
  input wire [7:0] addr,
  input wire [15:0] rangeCode,
  input wire [7:0] refByp,
  input wire [7:0] marker,
  input wire [7:0] swing,
  input wire [7:0] routing,
  output reg [7:0] readData_q
);
  reg [7:0] readData_d;

  always @* begin
    case (addr)
      `CFR_ADDR_RANGE_LO: readData_d = rangeCode[7:0];
      `CFR_ADDR_RANGE_HI: readData_d = rangeCode[15:8];
      `CFR_ADDR_REF_BYP: readData_d = refByp;
      `CFR_ADDR_MARKER: readData_d = marker;
      `CFR_ADDR_SWING: readData_d = swing;
      `CFR_ADDR_ROUTING: readData_d = routing;
      default: readData_d = 8'h00;
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      readData_q <= 8'h00;
    end else if (load) begin
      readData_q <= readData_d;
    end
  end
endmodule // cfr_read_mux

// >>> rtl/cfr_config_regs.v
// Notes on behaviour
// - 16-bit range code for second input, default a000
// - range code 2000 min recommended, ffff max
// - reference bypass bit swaps band-gap for supply
// - marker receiver enable bit, off after reset
// - marker dc-coupled signalling mode bit
// - two-bit output swing mode, 2 reserved
// - swap inputs in dual mode when interleave off
// - routing register resets to 01
// - single-channel source select when interleave on
//
// Decided for this implementation: the Avalon-MM slave port.
`include "cfr_defs.vh"
module cfr_config_regs #(
  parameter ADDR_W = 8
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire interleaveOn,
  output wire [15:0] inputBRangeCode,
  output wire rangeBelowRecommended,
  output reg rangeChanged_q,
  output wire referenceBypass,
  output wire markerReceiverEnable,
  output wire markerDcCoupledMode,
  output wire [1:0] swingMode,
  output wire swingReservedSelected,
  output wire chanASelectsSecond,
  output wire chanBSelectsSecond,
  output wire singleSourceSecond,
  output wire singleSourceValid
);
  // a read answers one cycle after it is seen: data come from a register
  reg readPending_q;
  wire [7:0] readByte;
  wire [7:0] rangeLo;
  wire [7:0] rangeHi;
  wire [7:0] refBypReg;
  wire [7:0] markerReg;
  wire [7:0] swingReg;
  wire [7:0] routingReg;
  wire [7:0] addr;
  wire wrLane0;
  // split the range reset into its two bytes without silent truncation
  localparam [15:0] RANGE_RESET = `CFR_RST_RANGE;

  assign addr = avs_address[7:0];
  // each register is one byte at its own byte address, low lane
  assign wrLane0 = avs_write && avs_byteenable[0];

  function isAddr;
    input [7:0] a;
    input [7:0] target;
    begin
      isAddr = (a == target);
    end
  endfunction

  // writes take effect on the single cycle with waitrequest low
  cfr_byte_reg #(.RESET_VALUE(RANGE_RESET[7:0])) uRangeLo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .writeEn(wrLane0 && isAddr(addr, `CFR_ADDR_RANGE_LO)),
    .writeData(avs_writedata[7:0]),
    .value_q(rangeLo)
  );
  cfr_byte_reg #(.RESET_VALUE(RANGE_RESET[15:8])) uRangeHi (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .writeEn(wrLane0 && isAddr(addr, `CFR_ADDR_RANGE_HI)),
    .writeData(avs_writedata[7:0]),
    .value_q(rangeHi)
  );
  // reserved bits are plain storage so they hold what was written
  cfr_byte_reg #(.RESET_VALUE(`CFR_RST_REF_BYP)) uRefByp (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .writeEn(wrLane0 && isAddr(addr, `CFR_ADDR_REF_BYP)),
    .writeData(avs_writedata[7:0]),
    .value_q(refBypReg)
  );
  cfr_byte_reg #(.RESET_VALUE(`CFR_RST_MARKER)) uMarker (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .writeEn(wrLane0 && isAddr(addr, `CFR_ADDR_MARKER)),
    .writeData(avs_writedata[7:0]),
    .value_q(markerReg)
  );
  cfr_byte_reg #(.RESET_VALUE(`CFR_RST_SWING)) uSwing (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .writeEn(wrLane0 && isAddr(addr, `CFR_ADDR_SWING)),
    .writeData(avs_writedata[7:0]),
    .value_q(swingReg)
  );
  cfr_byte_reg #(.RESET_VALUE(`CFR_RST_ROUTING)) uRouting (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .writeEn(wrLane0 && isAddr(addr, `CFR_ADDR_ROUTING)),
    .writeData(avs_writedata[7:0]),
    .value_q(routingReg)
  );

  // flag a range write that changes the code; software must recalibrate
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rangeChanged_q <= 1'b0;
    end else begin
      rangeChanged_q <= wrLane0 &&
        ((isAddr(addr, `CFR_ADDR_RANGE_LO) && avs_writedata[7:0] != rangeLo)
        || (isAddr(addr, `CFR_ADDR_RANGE_HI)
        && avs_writedata[7:0] != rangeHi));
    end
  end

  assign inputBRangeCode = {rangeHi, rangeLo};
  // low codes are still applied; this only warns of degraded performance
  assign rangeBelowRecommended =
    (inputBRangeCode < `CFR_RANGE_MIN_REC);

  assign referenceBypass = refBypReg[`CFR_BIT_REF_BYP];
  assign markerReceiverEnable = markerReg[`CFR_BIT_RECV_EN];
  assign markerDcCoupledMode = markerReg[`CFR_BIT_DC_MODE];

  // reserved code 2 passes through unchanged; flagged for the driver logic
  assign swingMode = swingReg[`CFR_SWING_HI:`CFR_SWING_LO];
  assign swingReservedSelected = (swingMode == `CFR_SWING_RSVD);

  // swap only matters with interleave off
  assign chanASelectsSecond =
    !interleaveOn && routingReg[`CFR_BIT_SWAP];
  assign chanBSelectsSecond =
    !interleaveOn && !routingReg[`CFR_BIT_SWAP];
  // single source only matters with interleave on; reserved codes invalid
  assign singleSourceSecond = interleaveOn &&
    (routingReg[`CFR_SINGLE_HI:`CFR_SINGLE_LO] == `CFR_SINGLE_B);
  assign singleSourceValid = interleaveOn &&
    ((routingReg[`CFR_SINGLE_HI:`CFR_SINGLE_LO] == `CFR_SINGLE_A)
    || (routingReg[`CFR_SINGLE_HI:`CFR_SINGLE_LO] == `CFR_SINGLE_B));

  cfr_read_mux uReadMux (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(avs_read && !readPending_q),
    .addr(addr),
    .rangeCode(inputBRangeCode),
    .refByp(refBypReg),
    .marker(markerReg),
    .swing(swingReg),
    .routing(routingReg),
    .readData_q(readByte)
  );

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      readPending_q <= 1'b0;
    end else begin
      readPending_q <= avs_read && !readPending_q;
    end
  end

  // writes complete at once; reads stall one cycle for the registered data
  assign avs_waitrequest = avs_read && !readPending_q;
  assign avs_readdata = {24'h000000, readByte};
endmodule // cfr_config_regs

// >>> tb/cfr_config_regs_properties.sv
module cfr_config_regs_properties #(
  parameter ADDR_W = 8
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_waitrequest,
  input wire interleaveOn,
  input wire [15:0] inputBRangeCode,
  input wire rangeBelowRecommended,
  input wire referenceBypass,
  input wire markerReceiverEnable,
  input wire markerDcCoupledMode,
  input wire [1:0] swingMode,
  input wire chanASelectsSecond,
  input wire chanBSelectsSecond,
  input wire singleSourceSecond,
  input wire singleSourceValid
);
  timeunit 1ns;
  timeprecision 1ns;
  wire wrEn = avs_write && avs_byteenable[0];
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  property p_wrNoWait; avs_write |-> !avs_waitrequest; endproperty
  a_wrNoWait: assert property (p_wrNoWait)
    else $error("write stalled");
  property p_rangeLo; wrEn && avs_address == 8'h32 |=>
    inputBRangeCode[7:0] == $past(avs_writedata[7:0]); endproperty
  a_rangeLo: assert property (p_rangeLo)
    else $error("range low byte not taken");
  property p_below;
    rangeBelowRecommended == (inputBRangeCode < 16'h2000); endproperty
  a_below: assert property (p_below)
    else $error("below flag wrong");
  property p_bypass; wrEn && avs_address == 8'h38 |=>
    referenceBypass == $past(avs_writedata[0]); endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass bit wrong");
  property p_marker; wrEn && avs_address == 8'h3b |=> {markerDcCoupledMode,
    markerReceiverEnable} == $past(avs_writedata[1:0]); endproperty
  a_marker: assert property (p_marker)
    else $error("marker bits wrong");
  property p_swing; wrEn && avs_address == 8'h48 |=>
    swingMode == $past(avs_writedata[1:0]); endproperty
  a_swing: assert property (p_swing)
    else $error("swing field wrong");
  property p_dual; interleaveOn ? !chanASelectsSecond && !chanBSelectsSecond
    : chanASelectsSecond != chanBSelectsSecond; endproperty
  a_dual: assert property (p_dual)
    else $error("dual mapping wrong");
  property p_single;
    singleSourceSecond |-> singleSourceValid && interleaveOn; endproperty
  a_single: assert property (p_single)
    else $error("single source wrong");
endmodule // cfr_config_regs_properties

// >>> tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic interleaveOn = 0, pulse;
  logic [7:0] avs_address = 0, m [6], adr [6];
  logic [31:0] avs_writedata = 0, q;
  logic [3:0] avs_byteenable = 0;
  logic [15:0] cv [4] = '{16'h1fff, 16'h2000, 16'h2000, 16'hffff};
  wire [31:0] avs_readdata;
  wire [15:0] inputBRangeCode;
  wire [1:0] swingMode;
  wire avs_waitrequest, rangeBelowRecommended, rangeChanged_q;
  wire referenceBypass, markerReceiverEnable, markerDcCoupledMode;
  wire swingReservedSelected, chanASelectsSecond, chanBSelectsSecond;
  wire singleSourceSecond, singleSourceValid;
  wire [26:0] outs = {inputBRangeCode, rangeBelowRecommended,
    referenceBypass, markerReceiverEnable, markerDcCoupledMode, swingMode,
    swingReservedSelected, chanASelectsSecond, chanBSelectsSecond,
    singleSourceSecond, singleSourceValid};
  int err_count = 0, checks_done = 0;
  cfr_config_regs #(.ADDR_W(8)) u_cfr_config_regs (.*);
  initial forever #5 sys_clk = ~sys_clk;
  function automatic logic [26:0] expOut(input logic il);
    return {m[1], m[0], {m[1], m[0]} < 16'h2000, m[2][0], m[3][0], m[3][1],
      m[4][1:0], m[4][1:0] == 2'h2, !il & m[5][4], !il & !m[5][4],
      il & m[5][1:0] == 2'h2, il & (m[5][1:0] == 2'h1 | m[5][1:0] == 2'h2)};
  endfunction
  task automatic cmp(input logic [31:0] got, exp, input string s);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, s);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input [7:0] a, d, input [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge sys_clk);
    pulse = rangeChanged_q;
  endtask
  task automatic rd(input int k, input [7:0] a);
    bus(0, a, 8'h00, 4'h0);
    cmp(q, k < 0 ? 32'h0 : {24'h0, m[k]}, "read data");
  endtask
  task automatic wrm(input int k, input [7:0] d);
    bus(1, adr[k], d, 4'h1);
    if (k < 2) cmp(pulse, d != m[k], "change pulse");
    m[k] = d;
    rd(k, adr[k]);
    cmp(outs, expOut(interleaveOn), "outputs");
  endtask
  task finish_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    finish_test;
  end
  initial begin
    void'($urandom(30));
    adr = '{8'h32, 8'h33, 8'h38, 8'h3b, 8'h48, 8'h60};
    m = '{8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h01};
    repeat (5) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) rd(i, adr[i]);
    cmp(outs, expOut(0), "reset outputs");
    bus(1, 8'h34, 8'h5a, 4'h1);
    rd(-1, 8'h34);
    bus(1, 8'h38, 8'hff, 4'h0);
    rd(2, 8'h38);
    for (int i = 0; i < 4; i++) begin
      wrm(0, cv[i][7:0]);
      wrm(1, cv[i][15:8]);
    end
    for (int v = 0; v < 8; v++) begin
      interleaveOn <= v[2];
      wrm(4, v[1:0]);
      wrm(5, {3'h0, v[0], 2'h0, v[1:0]});
    end
    repeat (40) begin
      interleaveOn <= 1'($urandom);
      wrm($urandom_range(5), 8'($urandom));
    end
    // second reset in mid-run: every byte must return to its reset value
    sys_rst <= 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    m = '{8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h01};
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) rd(i, adr[i]);
    cmp(pulse, 0, "change pulse after reset");
    cmp(outs, expOut(interleaveOn), "outputs after reset");
    finish_test;
  end
endmodule // tb_top
bind cfr_config_regs cfr_config_regs_properties #(.ADDR_W(ADDR_W)) u_props (.*);
